/* dof_pkg.sv */
// Package of constants, carrier types and mode decode for the dual converter output logic.
package dof_pkg;

    localparam int WORD_W = 14;
    localparam int RAW_W = 16;
    localparam int CHANNELS = 2;

    // Code points of the two output formats, the sleep word and the raw clamp limits.
    localparam logic [13:0] OB_NEG_FS = 14'h0000;
    localparam logic [13:0] OB_MID = 14'h2000;
    localparam logic [13:0] OB_POS_FS = 14'h3FFF;
    localparam logic [13:0] TC_NEG_FS = 14'h2000;
    localparam logic [13:0] TC_MID = 14'h0000;
    localparam logic [13:0] TC_POS_FS = 14'h1FFF;
    localparam logic [13:0] WORD_SLEEP = 14'h0000;
    localparam logic signed [15:0] RAW_POS_LIMIT = 16'sh1FFF;
    localparam logic signed [15:0] RAW_NEG_LIMIT = 16'shE000;

    // Levels of the four-level select pin after its comparator.
    localparam logic [1:0] SEL_GND = 2'h0;
    localparam logic [1:0] SEL_ONE_THIRD = 2'h1;
    localparam logic [1:0] SEL_TWO_THIRDS = 2'h2;
    localparam logic [1:0] SEL_SUPPLY = 2'h3;

    // Register map and field positions.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TIMING = 8'h08;
    localparam int CTRL_SER_EN_BIT = 0;
    localparam int CTRL_TWOS_BIT = 1;
    localparam int CTRL_STAB_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int TIMING_HIGH_LSB = 8;

    // Timing figures and their cycle counts at the system clock.
    localparam int SYS_CLK_PERIOD_NS = 40;
    localparam int OUTPUT_DELAY_NS = 80;
    localparam int OUT_DELAY_CYCLES = (OUTPUT_DELAY_NS / SYS_CLK_PERIOD_NS < 1) ? 1 :
        OUTPUT_DELAY_NS / SYS_CLK_PERIOD_NS;
    localparam int CLOCK_LOST_NS = 2000;
    localparam int CLOCK_LOST_CYCLES = (CLOCK_LOST_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int DUTY_MIN_PCT = 30;
    localparam int DUTY_MAX_PCT = 70;
    localparam int PCT_FULL = 100;

    // Format and stabilizer choice carried as one unit.
    typedef struct packed {
        logic twos;
        logic stab;
    } dof_mode_type;

    // Status register layout, high bits first in the word.
    typedef struct packed {
        logic clock_lost;
        logic duty_ok;
        logic b_sleep;
        logic a_sleep;
        logic stab;
        logic twos;
    } dof_status_type;

    typedef enum logic {PH_IDLE, PH_DELAY} dof_phase_type;

    // Decodes the select pin level into format and stabilizer choice.
    function automatic dof_mode_type sel_to_mode(input logic [1:0] sel);
        dof_mode_type m;
        m.twos = (sel == SEL_SUPPLY) || (sel == SEL_TWO_THIRDS);
        m.stab = (sel == SEL_TWO_THIRDS) || (sel == SEL_ONE_THIRD);
        return m;
    endfunction

endpackage

/* dof_code_format.sv */
// Saturating formatter that turns a signed core result into an output code.
`timescale 1ns/10ps
module dof_code_format
    import dof_pkg::*;
(
    input wire logic twos,
    input wire logic signed [15:0] raw,
    output logic [13:0] code
);

    logic [13:0] sat;

    // Clamp at full scale so an overrange input never wraps around.
    always_comb begin
        if (raw > RAW_POS_LIMIT) begin
            sat = RAW_POS_LIMIT[13:0];
        end else if (raw < RAW_NEG_LIMIT) begin
            sat = RAW_NEG_LIMIT[13:0];
        end else begin
            sat = raw[13:0];
        end
    end

    // One top-bit inversion yields offset binary; two's complement passes unchanged.
    assign code = twos ? sat : {~sat[13], sat[12:0]};

endmodule

/* dof_top.sv */
// Output formatting, strap decode, clock stabilizer and APB registers of the dual converter.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
module dof_top
    import dof_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sample_clock,
    input wire logic [1:0] format_stabilizer_select,
    input wire logic chan_a_sleep,
    input wire logic chan_b_sleep,
    input wire logic signed [15:0] chan_a_sample,
    input wire logic signed [15:0] chan_b_sample,
    output logic [13:0] channel_a_word,
    output logic [13:0] channel_b_word,
    output logic output_valid_strobe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    localparam int PIN_W = 5;
    localparam int DLY = OUT_DELAY_CYCLES;
    localparam logic [3:0] DLY_LOAD = 4'(OUT_DELAY_CYCLES - 1);
    localparam logic [7:0] LOST_COUNT = 8'(CLOCK_LOST_CYCLES);

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_level;
    logic clk_lvl;
    logic clk_prev;
    logic rise_evt;
    logic fall_evt;
    logic [1:0] sel_lvl;
    logic [CHANNELS-1:0] ch_sleep;
    logic [7:0] since_rise;
    logic [7:0] period;
    logic [7:0] high_time;
    logic duty_ok;
    logic clock_lost;
    logic int_clk;
    logic int_prev;
    logic int_fall;
    dof_phase_type phase;
    logic [3:0] dly_cnt;
    logic load_words;
    logic [2:0] ctrl;
    dof_mode_type pin_mode;
    dof_mode_type ser_mode;
    dof_mode_type mode;
    dof_status_type status;
    logic signed [15:0] raw [CHANNELS];
    logic signed [15:0] pend [CHANNELS];
    logic [13:0] fmt [CHANNELS];
    logic [13:0] word [CHANNELS];
    logic access;
    logic mapped;
    logic [31:0] next_prdata;

    assign pin_raw = {format_stabilizer_select, chan_b_sleep, chan_a_sleep, sample_clock};

    // Three-stage synchronisers; a level counts once the second and third stages agree.
    genvar g;
    generate
        for (g = 0; g < PIN_W; g++) begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    lvl <= 1'b0;
                end else if (clk_en) begin
                    s1 <= pin_raw[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        lvl <= s3;
                    end
                end
            end
            assign pin_level[g] = lvl;
        end
    endgenerate

    assign clk_lvl = pin_level[0];
    assign ch_sleep = pin_level[2:1];
    assign sel_lvl = pin_level[4:3];
    assign rise_evt = clk_lvl & ~clk_prev;
    assign fall_evt = ~clk_lvl & clk_prev;

    // Serial control overrides the strap pin whenever its enable bit is set.
    assign pin_mode = sel_to_mode(sel_lvl);
    assign ser_mode = '{twos: ctrl[CTRL_TWOS_BIT], stab: ctrl[CTRL_STAB_BIT]};
    assign mode = ctrl[CTRL_SER_EN_BIT] ? ser_mode : pin_mode;

    // Measures period and high time of the sampling clock in system cycles.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clk_prev <= 1'b0;
            since_rise <= 8'h00;
            period <= 8'h00;
            high_time <= 8'h00;
        end else if (clk_en) begin
            clk_prev <= clk_lvl;
            if (rise_evt) begin
                period <= since_rise;
                since_rise <= 8'h01;
            end else if (since_rise != 8'hFF) begin
                since_rise <= since_rise + 8'h01;
            end
            if (fall_evt) begin
                high_time <= since_rise;
            end
        end
    end

    // Duty check against the accepted window, and a watchdog on a stalled clock.
    assign duty_ok = (period != 8'h00) &&
        (16'(high_time) * 16'(PCT_FULL) >= 16'(period) * 16'(DUTY_MIN_PCT)) &&
        (16'(high_time) * 16'(PCT_FULL) <= 16'(period) * 16'(DUTY_MAX_PCT));
    assign clock_lost = since_rise >= LOST_COUNT;

    // Internal clock: rebuilt at half the measured period when stabilized, else followed.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_clk <= 1'b0;
            int_prev <= 1'b0;
        end else if (clk_en) begin
            int_prev <= int_clk;
            if (!mode.stab) begin
                int_clk <= clk_lvl;
            end else if (rise_evt) begin
                int_clk <= 1'b1;
            end else if (int_clk && (since_rise >= {1'b0, period[7:1]})) begin
                int_clk <= 1'b0;
            end
        end
    end

    assign int_fall = int_prev & ~int_clk;
    assign output_valid_strobe = int_clk;

    // Samples are taken at the internal falling edge and shown after the output delay.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase <= PH_IDLE;
            dly_cnt <= 4'h0;
        end else if (clk_en) begin
            if (int_fall) begin
                phase <= PH_DELAY;
                dly_cnt <= DLY_LOAD;
            end else begin
                unique case (phase)
                    PH_IDLE: begin
                        dly_cnt <= 4'h0;
                    end
                    PH_DELAY: begin
                        if (dly_cnt == 4'h0) begin
                            phase <= PH_IDLE;
                        end else begin
                            dly_cnt <= dly_cnt - 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    assign load_words = (phase == PH_DELAY) && (dly_cnt == 4'h0) && !int_fall;
    assign raw[0] = chan_a_sample;
    assign raw[1] = chan_b_sample;

    // Per-channel capture, formatting and word register.
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            dof_code_format u_fmt (
                .twos(mode.twos),
                .raw(pend[g]),
                .code(fmt[g])
            );
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    pend[g] <= 16'sh0000;
                    word[g] <= WORD_SLEEP;
                end else if (clk_en) begin
                    if (int_fall) begin
                        pend[g] <= raw[g];
                    end
                    if (ch_sleep[g]) begin
                        word[g] <= WORD_SLEEP;
                    end else if (load_words) begin
                        word[g] <= fmt[g];
                    end
                end
            end
        end
    endgenerate

    assign channel_a_word = word[0];
    assign channel_b_word = word[1];

    // APB slave: zero wait states while clk_en is high, error on unmapped addresses.
    assign access = psel & penable;
    assign pready = clk_en;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_TIMING);
    assign pslverr = access & ~mapped;
    assign status = '{clock_lost: clock_lost, duty_ok: duty_ok, b_sleep: ch_sleep[1],
        a_sleep: ch_sleep[0], stab: mode.stab, twos: mode.twos};

    // Read data is chosen in the setup cycle and held through the access phase.
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr == REG_CTRL) begin
            next_prdata = {29'h0, ctrl};
        end else if (paddr == REG_STATUS) begin
            next_prdata = {26'h0, status};
        end else if (paddr == REG_TIMING) begin
            next_prdata = {16'h0, high_time, period};
        end
    end

    // Control register writes take effect at the completing access edge.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl <= CTRL_RESET;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
            if (access && pwrite && (paddr == REG_CTRL)) begin
                ctrl <= pwdata[2:0];
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || !clk_en);

    AST_OB_NEG_FS: assert property (
        load_words && !mode.twos && !ch_sleep[0] && (pend[0] <= RAW_NEG_LIMIT)
        |=> channel_a_word == OB_NEG_FS)
        else $error("offset binary negative full scale code wrong");

    AST_OB_MID_POS: assert property (
        load_words && !mode.twos && !ch_sleep[1] && (pend[1] == 16'sh0000)
        |=> channel_b_word == OB_MID)
        else $error("offset binary mid scale code wrong");

    AST_TC_NEG_FS: assert property (
        load_words && mode.twos && !ch_sleep[0] && (pend[0] <= RAW_NEG_LIMIT)
        |=> channel_a_word == TC_NEG_FS)
        else $error("two's complement negative full scale code wrong");

    AST_TC_SAT_POS: assert property (
        load_words && mode.twos && !ch_sleep[0] && (pend[0] > RAW_POS_LIMIT)
        |=> channel_a_word == TC_POS_FS)
        else $error("overrange input not saturated");

    AST_OB_SAT_POS: assert property (
        load_words && !mode.twos && !ch_sleep[1] && (pend[1] > RAW_POS_LIMIT)
        |=> channel_b_word == OB_POS_FS)
        else $error("offset binary positive full scale code wrong");

    AST_STRAP_DECODE: assert property (
        !ctrl[CTRL_SER_EN_BIT] |->
        mode.twos == sel_lvl[1] && mode.stab == (sel_lvl[1] ^ sel_lvl[0]))
        else $error("strap level decoded to wrong mode");

    AST_SERIAL_OVERRIDE: assert property (
        ctrl[CTRL_SER_EN_BIT] && $changed(sel_lvl) |-> $stable(mode))
        else $error("select pin changed mode under serial control");

    AST_OUT_DELAY: assert property (
        int_fall ##1 !int_fall [*2] |-> ##(DLY - 2) load_words)
        else $error("word update not at the fixed output delay");

    AST_SLEEP_ZERO: assert property (
        ch_sleep[0] |=> channel_a_word == WORD_SLEEP)
        else $error("sleeping channel shows data");

    AST_STROBE_STABLE: assert property (
        $rose(output_valid_strobe) |-> $stable(channel_a_word) && $stable(channel_b_word))
        else $error("word moved at data-ready rising edge");

    AST_STAB_RISE: assert property (
        mode.stab && rise_evt |=> output_valid_strobe)
        else $error("stabilized clock missed a rising edge");

    COV_TWOS_LOAD: cover property (load_words && mode.twos);
    COV_STAB_STROBE: cover property (mode.stab && $rose(output_valid_strobe));
    COV_CTRL_WRITE: cover property (access && pwrite && paddr == REG_CTRL);
    COV_SLEEP: cover property ($rose(ch_sleep[1]));

endmodule

/* dof_capture_model.sv */
// Capture model that latches both channel words on the rising data-ready strobe.
`timescale 1ns/10ps
module dof_capture_model
    import dof_pkg::*;
(
    input wire logic output_valid_strobe,
    input wire logic [13:0] channel_a_word,
    input wire logic [13:0] channel_b_word,
    output logic [13:0] cap_a,
    output logic [13:0] cap_b,
    output logic [15:0] cap_count
);
    logic [15:0] n_caps = 16'h0000;

    assign cap_count = n_caps;

    // Both words are taken on the strobe rise only, never on the sampling clock.
    always @(posedge output_valid_strobe) begin
        cap_a <= channel_a_word;
        cap_b <= channel_b_word;
        n_caps <= n_caps + 16'h0001;
    end
endmodule

/* tb_dual_adc_output_format_capture.sv */
// Self-checking testbench for the converter output formatting block.
`timescale 1ns/10ps
module tb_dual_adc_output_format_capture
    import dof_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic sample_clock = 1'b0;
    logic [1:0] format_stabilizer_select = SEL_GND;
    logic chan_a_sleep = 1'b0;
    logic chan_b_sleep = 1'b0;
    logic signed [15:0] chan_a_sample = 16'h0000;
    logic signed [15:0] chan_b_sample = 16'h0000;
    logic [13:0] channel_a_word;
    logic [13:0] channel_b_word;
    logic output_valid_strobe;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [13:0] cap_a;
    logic [13:0] cap_b;
    logic [15:0] cap_count;
    logic [31:0] rd;
    logic err;
    int hi_ns = 160;
    int mismatches = 0;
    int n_tests = 0;

    dof_top u_dut (.clk, .reset_n, .clk_en, .sample_clock, .format_stabilizer_select,
        .chan_a_sleep, .chan_b_sleep, .chan_a_sample, .chan_b_sample, .channel_a_word,
        .channel_b_word, .output_valid_strobe, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);

    dof_capture_model u_cap (.output_valid_strobe, .channel_a_word, .channel_b_word,
        .cap_a, .cap_b, .cap_count);

    // System clock at 25 MHz.
    initial begin
        forever #20 clk = ~clk;
    end

    // Free-running 320 ns sampling clock, offset in phase, with adjustable high time.
    initial begin
        #10;
        forever begin
            sample_clock = 1'b1;
            #(hi_ns);
            sample_clock = 1'b0;
            #(320 - hi_ns);
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready and takes data and response at that edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        // This wait ends at the first edge that sees pready high.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for n new captures so the words reflect settled inputs and mode.
    task automatic wait_caps(input int n);
        logic [15:0] start;
        int i;
        start = cap_count;
        for (i = 0; i < 40 * n; i++) begin
            @(posedge clk);
            if (16'(cap_count - start) >= 16'(n)) break;
        end
        check(32'(16'(cap_count - start) >= 16'(n)), 32'h1);
    endtask

    // Saturates and offsets a raw value, then flips the top bit for two's complement.
    function automatic logic [13:0] exp_code(input int raw, input logic twos);
        int s;
        s = raw > 8191 ? 8191 : (raw < -8192 ? -8192 : raw);
        exp_code = 14'(s + 8192) ^ {twos, 13'h0000};
    endfunction

    task automatic drive(input logic [1:0] sel, input int a, input int b);
        @(posedge clk);
        format_stabilizer_select <= sel;
        chan_a_sample <= 16'(a);
        chan_b_sample <= 16'(b);
        wait_caps(3);
    endtask

    task automatic strobe_high(output int cnt);
        int i;
        cnt = 0;
        for (i = 0; i < 40 && output_valid_strobe !== 1'b0; i++) @(posedge clk);
        for (i = 0; i < 40 && output_valid_strobe !== 1'b1; i++) @(posedge clk);
        for (i = 0; i < 40 && output_valid_strobe === 1'b1; i++) begin
            @(posedge clk);
            cnt++;
        end
    endtask

    task automatic test_formats();
        int v[5] = '{-8192, 0, 8191, 9000, -9000};
        logic [1:0] sel;
        for (int s = 0; s < 4; s++) begin
            sel = 2'(s);
            for (int k = 0; k < 5; k++) begin
                drive(sel, v[k], -v[k]);
                check(32'(cap_a), 32'(exp_code(v[k], sel[1])));
                check(32'(cap_b), 32'(exp_code(-v[k], sel[1])));
            end
            apb(1'b0, REG_STATUS, 32'h0);
            check(rd & 32'h3, {30'h0, sel[1] ^ sel[0], sel[1]});
        end
    endtask

    task automatic test_serial();
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h3);
        drive(SEL_GND, 256, -256);
        check(32'(cap_a), 32'(exp_code(256, 1'b1)));
        apb(1'b1, REG_CTRL, 32'h1);
        drive(SEL_SUPPLY, 256, -256);
        check(32'(cap_b), 32'(exp_code(-256, 1'b0)));
        apb(1'b1, REG_STATUS, 32'h3F);
        check(32'(err), 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd & 32'h3, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, REG_CTRL, 32'h0);
        drive(SEL_SUPPLY, 256, -256);
        check(32'(cap_a), 32'(exp_code(256, 1'b1)));
    endtask

    task automatic test_sleep();
        chan_a_sleep <= 1'b1;
        drive(SEL_GND, 1000, -1000);
        check(32'(cap_a), 32'h0);
        check(32'(cap_b), 32'(exp_code(-1000, 1'b0)));
        apb(1'b0, REG_STATUS, 32'h0);
        check((rd >> 2) & 32'h3, 32'h1);
        chan_a_sleep <= 1'b0;
        chan_b_sleep <= 1'b1;
        drive(SEL_GND, 1000, -1000);
        check(32'(cap_a), 32'(exp_code(1000, 1'b0)));
        check(32'(cap_b), 32'h0);
        chan_b_sleep <= 1'b0;
    endtask

    // Clock enable low freezes the block for two whole sampling periods.
    task automatic test_freeze();
        logic [15:0] n0;
        @(posedge clk);
        clk_en <= 1'b0;
        @(posedge clk);
        n0 = cap_count;
        repeat (15) @(posedge clk);
        check(32'(pready), 32'h0);
        check(32'(cap_count - n0), 32'h0);
        clk_en <= 1'b1;
        wait_caps(2);
    endtask

    task automatic test_stabilizer();
        int cnt;
        hi_ns = 112;
        drive(SEL_GND, -77, 77);
        strobe_high(cnt);
        check(32'(cnt), 32'h3);
        drive(SEL_ONE_THIRD, -77, 77);
        strobe_high(cnt);
        check(32'(cnt == 4 || cnt == 5), 32'h1);
        check(32'(cap_a), 32'(exp_code(-77, 1'b0)));
        apb(1'b0, REG_STATUS, 32'h0);
        check((rd >> 4) & 32'h1, 32'h1);
        apb(1'b0, REG_TIMING, 32'h0);
        check(rd, 32'(3 << TIMING_HIGH_LSB) | 32'h8);
        hi_ns = 160;
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence: reset, then every scenario in turn.
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h0);
        test_formats();
        test_serial();
        test_sleep();
        test_freeze();
        test_stabilizer();
        end_of_test();
    end

    // Watchdog that ends a hung run as a failure.
    initial begin
        #2000000;
        mismatches++;
        end_of_test();
    end
endmodule
